/* File: verilog/sfcfe_pkg.sv */
// Shared constants and types of the serial flash command front end.
package sfcfe_pkg;

  // Command opcodes.
  localparam logic [7:0] OP_STATUS_STORE  = 8'h01;
  localparam logic [7:0] OP_CONFIG_STORE  = 8'h31;
  localparam logic [7:0] OP_IDENT_FETCH   = 8'h9f;
  localparam logic [7:0] OP_MAKER_DEV     = 8'h90;
  localparam logic [7:0] OP_MAKER_DEV_X2  = 8'h92;
  localparam logic [7:0] OP_MAKER_DEV_X4  = 8'h94;
  localparam logic [7:0] OP_SLEEP_DEEP    = 8'hb9;
  localparam logic [7:0] OP_WAKE_IDENT    = 8'hab;
  localparam logic [7:0] OP_WRITE_ARM     = 8'h06;
  localparam logic [7:0] OP_WRITE_DISARM  = 8'h04;
  localparam logic [7:0] OP_VOLATILE_ARM  = 8'h50;
  localparam logic [7:0] OP_STATUS_LO     = 8'h05;
  localparam logic [7:0] OP_STATUS_HI     = 8'h35;
  localparam logic [7:0] OP_CONFIG_FETCH  = 8'h15;
  localparam logic [7:0] OP_BUSY_WATCH    = 8'h25;
  localparam logic [7:0] OP_RESET_ARM     = 8'h66;
  localparam logic [7:0] OP_RESET         = 8'h99;
  localparam logic [7:0] OP_PAGE_WRITE    = 8'h02;
  localparam logic [7:0] OP_PAGE_WRITE_X2 = 8'ha2;
  localparam logic [7:0] OP_PAGE_WRITE_X4 = 8'h32;
  localparam logic [7:0] OP_PAGE_ERASE    = 8'h81;
  localparam logic [7:0] OP_SECTOR_WIPE   = 8'h20;
  localparam logic [7:0] OP_HALF_BLK_WIPE = 8'h52;
  localparam logic [7:0] OP_BLOCK_WIPE    = 8'hd8;
  localparam logic [7:0] OP_CHIP_WIPE_A   = 8'h60;
  localparam logic [7:0] OP_CHIP_WIPE_B   = 8'hc7;
  localparam logic [7:0] OP_OTP_WIPE      = 8'h44;
  localparam logic [7:0] OP_OTP_WRITE     = 8'h42;

  // Frame lengths in serial clocks, counted from chip select low.
  localparam logic [5:0] CNT_OPCODE       = 6'h08;
  localparam logic [5:0] CNT_STORE_ONE    = 6'h10;
  localparam logic [5:0] CNT_STORE_TWO    = 6'h18;
  localparam logic [5:0] CNT_ADDR_X1      = 6'h20;
  localparam logic [5:0] CNT_ADDR_X2      = 6'h18;
  localparam logic [5:0] CNT_ADDR_X4      = 6'h10;
  localparam logic [5:0] CNT_DUMMY_X4     = 6'h04;
  localparam logic [5:0] CNT_MAX          = 6'h3f;

  // Lane width codes: shift amount of bits per clock.
  localparam logic [1:0] LANE_X1          = 2'h0;
  localparam logic [1:0] LANE_X2          = 2'h1;
  localparam logic [1:0] LANE_X4          = 2'h2;

  // Status field positions and write masks.
  localparam int         ST_BUSY_BIT      = 0;
  localparam int         ST_ARM_BIT       = 1;
  localparam logic [15:0] ST_KEEP_TWO     = 16'h8403;
  localparam logic [15:0] ST_KEEP_ONE     = 16'hff03;
  localparam logic [15:0] ST_RESET        = 16'h0000;
  localparam logic [7:0]  CFG_RESET       = 8'h00;

  // Security register selection on address bits 23..9.
  localparam logic [7:0] OTP_HI_BYTE      = 8'h00;
  localparam logic [6:0] OTP_REGION_1     = 7'b0001000;
  localparam logic [6:0] OTP_REGION_2     = 7'b0010000;
  localparam logic [6:0] OTP_REGION_3     = 7'b0011000;

  // Self-timed store cycle.
  localparam int         MCLK_MHZ         = 50;
  localparam int         STORE_TIME_US    = 2000;
  localparam int         STORE_CYCLES     = STORE_TIME_US * MCLK_MHZ;

  // Frame record left by the link side at chip select high.
  typedef struct packed {
    logic [7:0]  op;
    logic [5:0]  cnt;
    logic [31:0] inbuf;
    logic [23:0] addr;
  } sfcfe_frame_s;

  // Device state shown to the link side.
  typedef struct packed {
    logic        sleep;
    logic [7:0]  cfg;
    logic [15:0] status;
  } sfcfe_view_s;

endpackage

/* File: verilog/sfcfe_front_end.sv */
// Command front end of a serial flash: link shifter, command decode and write-arm control.
`timescale 1ns/1ns

module sfcfe_front_end #(
  parameter int          STORE_CYC = sfcfe_pkg::STORE_CYCLES,
  parameter logic [7:0]  MAKER_ID  = 8'h5a,   // Arbitrary value.
  parameter logic [15:0] DEVICE_ID = 16'h1234, // Arbitrary value.
  parameter logic [7:0]  ELEC_ID   = 8'h33    // Arbitrary value.
) (
  // System clock and reset.
  input  wire logic        i_mclk,
  input  wire logic        i_arst_n,
  // Serial link from the host.
  input  wire logic        i_sclk,
  input  wire logic        i_cs_n,
  input  wire logic [3:0]  i_io,
  output logic      [3:0]  o_io,
  output logic      [3:0]  o_io_oe_n,
  // Array engine handshake.
  output logic             o_op_req,
  output logic      [7:0]  o_op_code,
  output logic      [23:0] o_op_addr,
  output logic      [1:0]  o_otp_region,
  input  wire logic        i_array_busy,
  input  wire logic        i_op_done,
  // Device state.
  output logic      [15:0] o_status,
  output logic      [15:0] o_nv_status,
  output logic      [7:0]  o_config,
  output logic             o_deep_sleep,
  output logic             o_write_arm_flag,
  output logic             o_busy_flag,
  output logic             o_soft_reset
);
  import sfcfe_pkg::*;

  typedef enum logic [0:0] {ST_IDLE, ST_STORE} sfcfe_store_e;

  // Lane width used for input shifting at a given clock of the frame.
  function automatic logic [1:0] in_width(input logic [7:0] op, input logic [5:0] cnt);
    if (op == OP_MAKER_DEV_X2 && cnt >= CNT_OPCODE && cnt < CNT_ADDR_X2) begin
      in_width = LANE_X2;
    end else if (op == OP_MAKER_DEV_X4 && cnt >= CNT_OPCODE && cnt < CNT_ADDR_X4) begin
      in_width = LANE_X4;
    end else begin
      in_width = LANE_X1;
    end
  endfunction

  // Lane width used for output data.
  function automatic logic [1:0] out_width(input logic [7:0] op);
    case (op)
      OP_MAKER_DEV_X2: out_width = LANE_X2;
      OP_MAKER_DEV_X4: out_width = LANE_X4;
      default:         out_width = LANE_X1;
    endcase
  endfunction

  // Clock count at which output data starts, zero when the command returns nothing.
  function automatic logic [5:0] out_start(input logic [7:0] op);
    case (op)
      OP_STATUS_LO, OP_STATUS_HI, OP_CONFIG_FETCH, OP_IDENT_FETCH: out_start = CNT_OPCODE;
      OP_MAKER_DEV, OP_WAKE_IDENT:                                 out_start = CNT_ADDR_X1;
      OP_MAKER_DEV_X2:                                             out_start = CNT_ADDR_X2;
      OP_MAKER_DEV_X4:                                   out_start = CNT_ADDR_X4 + CNT_DUMMY_X4;
      default:                                                     out_start = 6'h00;
    endcase
  endfunction

  // Places one byte slot on the lanes, most significant bits first.
  function automatic logic [3:0] lane_bits(input logic [7:0] b, input logic [1:0] w, input logic [2:0] s);
    logic [7:0] sh;
    sh = b << (s << w);
    case (w)
      LANE_X2: lane_bits = {2'b00, sh[7], sh[6]};
      LANE_X4: lane_bits = sh[7:4];
      default: lane_bits = {2'b00, sh[7], 1'b0};
    endcase
  endfunction

  // Security region number of an address, zero when outside them.
  function automatic logic [1:0] otp_region(input logic [23:0] a);
    otp_region = 2'h0;
    if (a[23:16] == OTP_HI_BYTE) begin
      case (a[15:9])
        OTP_REGION_1: otp_region = 2'h1;
        OTP_REGION_2: otp_region = 2'h2;
        OTP_REGION_3: otp_region = 2'h3;
        default:      otp_region = 2'h0;
      endcase
    end
  endfunction

  // True for commands that change content and need the write arm flag.
  function automatic logic is_content_op(input logic [7:0] op);
    case (op)
      OP_PAGE_WRITE, OP_PAGE_WRITE_X2, OP_PAGE_WRITE_X4, OP_PAGE_ERASE, OP_SECTOR_WIPE,
      OP_HALF_BLK_WIPE, OP_BLOCK_WIPE, OP_CHIP_WIPE_A, OP_CHIP_WIPE_B, OP_OTP_WIPE,
      OP_OTP_WRITE: is_content_op = 1'b1;
      default:      is_content_op = 1'b0;
    endcase
  endfunction

  // ---------------- Link clock domain ----------------
  logic               lrst_n;
  logic [5:0]         cnt;
  logic               watch_on;
  logic [7:0]         op;
  logic [31:0]        inbuf;
  logic [23:0]        addr;
  logic [31:0]        next_inbuf;
  logic [1:0]         w_in;
  sfcfe_view_s        view_s1;
  sfcfe_view_s        view_s2;
  sfcfe_view_s        view_m;
  logic [4:0]         ocnt;
  logic [3:0]         lanes;
  logic [3:0]         lanes_oe;
  logic [1:0]         w_out;
  logic [1:0]         byte_idx;
  logic [2:0]         slot;
  logic [7:0]         resp;
  logic [5:0]         start;
  logic [5:0]         cnt_last;

  // Chip select high clears the frame logic at once, which also floats the lanes.
  assign lrst_n = i_arst_n & ~i_cs_n;

  // Next input shift value: one, two or four lanes per rising edge.
  always_comb begin
    w_in = in_width(op, cnt);
    case (w_in)
      LANE_X2: next_inbuf = {inbuf[29:0], i_io[1], i_io[0]};
      LANE_X4: next_inbuf = {inbuf[27:0], i_io[3:0]};
      default: next_inbuf = {inbuf[30:0], i_io[0]};
    endcase
  end

  // Rising-edge clock counter and busy-watch entry.
  always_ff @(posedge i_sclk or negedge lrst_n) begin
    if (!lrst_n) begin
      cnt      <= 6'h00;
      watch_on <= 1'b0;
    end else begin
      if (cnt != CNT_MAX) begin
        cnt <= cnt + 6'h01;
      end
      if (op == OP_BUSY_WATCH && cnt >= CNT_OPCODE) begin
        watch_on <= 1'b1;
      end
    end
  end

  // Frame record, clock count included; kept across chip select high so the system side can read it.
  // The count is not cleared by chip select, so a frame without any clock edge leaves the last record.
  always_ff @(posedge i_sclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      op       <= 8'h00;
      inbuf    <= 32'h0000_0000;
      addr     <= 24'h00_0000;
      cnt_last <= 6'h00;
    end else begin
      if (cnt != CNT_MAX) begin
        cnt_last <= cnt + 6'h01;
      end
      if (cnt < CNT_OPCODE) begin
        op <= {op[6:0], i_io[0]};
      end else begin
        inbuf <= next_inbuf;
      end
      if (op == OP_MAKER_DEV_X2 && cnt == CNT_ADDR_X2 - 6'h01) begin
        addr <= next_inbuf[31:8];
      end else if (op == OP_MAKER_DEV_X4 && cnt == CNT_ADDR_X4 - 6'h01) begin
        addr <= next_inbuf[31:8];
      end else if (op != OP_MAKER_DEV_X2 && op != OP_MAKER_DEV_X4 && cnt == CNT_ADDR_X1 - 6'h01) begin
        addr <= next_inbuf[23:0];
      end
    end
  end

  // Device state brought into the link domain through two flip-flops.
  always_ff @(posedge i_sclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      view_s1 <= '0;
      view_s2 <= '0;
    end else begin
      view_s1 <= view_m;
      view_s2 <= view_s1;
    end
  end

  // Response byte for the current byte index.
  always_comb begin
    start    = out_start(op);
    w_out    = out_width(op);
    byte_idx = 2'(ocnt >> (3'd3 - 3'(w_out)));
    slot     = 3'(ocnt & ((5'd8 >> w_out) - 5'd1));
    case (op)
      OP_STATUS_LO:    resp = view_s2.status[7:0];
      OP_STATUS_HI:    resp = view_s2.status[15:8];
      OP_CONFIG_FETCH: resp = view_s2.cfg;
      OP_WAKE_IDENT:   resp = ELEC_ID;
      OP_IDENT_FETCH: begin
        case (byte_idx)
          2'h1:    resp = DEVICE_ID[15:8];
          2'h2:    resp = DEVICE_ID[7:0];
          default: resp = MAKER_ID;
        endcase
      end
      default:         resp = (byte_idx[0] ^ addr[0]) ? DEVICE_ID[7:0] : MAKER_ID;
    endcase
  end

  // Falling-edge output shifter; only wake ident answers during deep sleep.
  always_ff @(negedge i_sclk or negedge lrst_n) begin
    if (!lrst_n) begin
      ocnt     <= 5'h00;
      lanes    <= 4'h0;
      lanes_oe <= 4'h0;
    end else if (start != 6'h00 && cnt >= start && (!view_s2.sleep || op == OP_WAKE_IDENT)) begin
      ocnt  <= ocnt + 5'h01;
      lanes <= lane_bits(resp, w_out, slot);
      case (w_out)
        LANE_X2: lanes_oe <= 4'h3;
        LANE_X4: lanes_oe <= 4'hf;
        default: lanes_oe <= 4'h2;
      endcase
    end
  end

  // Busy watch puts the live busy flag on line one without any clock.
  assign o_io      = {lanes[3:2], watch_on ? o_busy_flag : lanes[1], lanes[0]};
  assign o_io_oe_n = ~(lanes_oe | {2'b00, watch_on, 1'b0});

  // ---------------- System clock domain ----------------
  logic               cs1;
  logic               cs2;
  logic               cs3;
  logic               cs_q;
  logic               frame_end;
  sfcfe_frame_s       fr;
  logic               exact;
  logic               store_ok;
  logic               cfg_ok;
  logic               busy;
  logic               accept;
  logic               vol_arm;
  logic               reset_arm;
  logic [15:0]        st_vol;
  logic [15:0]        next_st;
  logic [7:0]         pend_cfg;
  logic [15:0]        pend_st;
  logic               pend_is_cfg;
  logic [23:0]        timer;
  sfcfe_store_e       store_state;
  logic               store_done;
  logic               soft_reset;

  // Chip select passes three flip-flops; a change counts when the last two agree.
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cs1  <= 1'b1;
      cs2  <= 1'b1;
      cs3  <= 1'b1;
      cs_q <= 1'b1;
    end else begin
      cs1 <= i_cs_n;
      cs2 <= cs1;
      cs3 <= cs2;
      if (cs2 == cs3) begin
        cs_q <= cs3;
      end
    end
  end

  // Frame end decode; the record is stable since the link clock idles while deselected.
  always_comb begin
    frame_end = ~cs_q & cs2 & cs3;
    fr        = '{op: op, cnt: cnt_last, inbuf: inbuf, addr: addr};
    busy      = (store_state == ST_STORE) | i_array_busy;
    accept    = frame_end & ~busy & ~o_deep_sleep;
    exact     = fr.cnt == CNT_OPCODE;
    store_ok  = fr.op == OP_STATUS_STORE && (fr.cnt == CNT_STORE_ONE || fr.cnt == CNT_STORE_TWO);
    cfg_ok    = fr.op == OP_CONFIG_STORE && fr.cnt == CNT_STORE_ONE;
    if (fr.cnt == CNT_STORE_TWO) begin
      next_st = (st_vol & ST_KEEP_TWO) | ({fr.inbuf[7:0], fr.inbuf[15:8]} & ~ST_KEEP_TWO);
    end else begin
      next_st = (st_vol & ST_KEEP_ONE) | ({8'h00, fr.inbuf[7:0]} & ~ST_KEEP_ONE);
    end
  end

  // Write arm flag: set by arm, cleared by disarm, store completion, array done, reset.
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_write_arm_flag <= 1'b0;
    end else if (accept && exact && fr.op == OP_WRITE_ARM) begin
      o_write_arm_flag <= 1'b1;
    end else if (accept && exact && fr.op == OP_WRITE_DISARM) begin
      o_write_arm_flag <= 1'b0;
    end else if (store_done || i_op_done || soft_reset) begin
      o_write_arm_flag <= 1'b0;
    end
  end

  // Volatile arm and reset arm last for the next frame only.
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      vol_arm   <= 1'b0;
      reset_arm <= 1'b0;
    end else if (frame_end) begin
      vol_arm   <= accept && exact && fr.op == OP_VOLATILE_ARM;
      reset_arm <= accept && exact && fr.op == OP_RESET_ARM;
    end
  end

  // Software reset pulse.
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      soft_reset <= 1'b0;
    end else begin
      soft_reset <= accept && exact && reset_arm && fr.op == OP_RESET;
    end
  end

  // Self-timed store of status or config; busy while the timer runs.
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      store_state <= ST_IDLE;
      timer       <= 24'h00_0000;
      store_done  <= 1'b0;
      pend_st     <= ST_RESET;
      pend_cfg    <= CFG_RESET;
      pend_is_cfg <= 1'b0;
    end else begin
      store_done <= 1'b0;
      case (store_state)
        ST_IDLE: begin
          if (accept && o_write_arm_flag && !vol_arm && (store_ok || cfg_ok)) begin
            store_state <= ST_STORE;
            timer       <= 24'(STORE_CYC - 1);
            pend_st     <= next_st;
            pend_cfg    <= fr.inbuf[7:0];
            pend_is_cfg <= cfg_ok;
          end
        end
        ST_STORE: begin
          if (timer == 24'h00_0000) begin
            store_state <= ST_IDLE;
            store_done  <= 1'b1;
          end else begin
            timer <= timer - 24'h00_0001;
          end
        end
        default: store_state <= ST_IDLE;
      endcase
    end
  end

  // Status and config contents; volatile store applies at once and leaves the flag alone.
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_vol      <= ST_RESET;
      o_nv_status <= ST_RESET;
      o_config    <= CFG_RESET;
    end else if (accept && vol_arm && store_ok) begin
      st_vol <= next_st;
    end else if (store_done && pend_is_cfg) begin
      o_config <= pend_cfg;
    end else if (store_done) begin
      st_vol      <= pend_st;
      o_nv_status <= pend_st;
    end else if (soft_reset) begin
      st_vol <= o_nv_status;
    end
  end

  // Deep sleep: entered by its opcode, left by wake ident in any frame of eight clocks or more.
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_deep_sleep <= 1'b0;
    end else if (frame_end && fr.op == OP_WAKE_IDENT && fr.cnt >= CNT_OPCODE) begin
      o_deep_sleep <= 1'b0;
    end else if (accept && exact && fr.op == OP_SLEEP_DEEP) begin
      o_deep_sleep <= 1'b1;
    end
  end

  // Content-changing requests go to the array engine only with the flag set.
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_op_req     <= 1'b0;
      o_op_code    <= 8'h00;
      o_op_addr    <= 24'h00_0000;
      o_otp_region <= 2'h0;
    end else begin
      o_op_req <= accept && o_write_arm_flag && is_content_op(fr.op) && fr.cnt >= CNT_OPCODE;
      if (accept && is_content_op(fr.op)) begin
        o_op_code    <= fr.op;
        o_op_addr    <= fr.addr;
        o_otp_region <= otp_region(fr.addr);
      end
    end
  end

  // Busy flag register and the view handed to the link side.
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_busy_flag <= 1'b0;
    end else begin
      o_busy_flag <= busy;
    end
  end

  always_comb begin
    o_status              = st_vol;
    o_status[ST_BUSY_BIT] = o_busy_flag;
    o_status[ST_ARM_BIT]  = o_write_arm_flag;
    view_m                = '{sleep: o_deep_sleep, cfg: o_config, status: o_status};
    o_soft_reset          = soft_reset;
  end

endmodule

/* File: sim/sfcfe_host.sv */
// Host link model that drives chip select, the link clock and the data lines.
`timescale 1ns/1ns
module sfcfe_host (
  // Link pins toward the device.
  output logic       o_sclk,
  output logic       o_cs_n,
  output logic [3:0] o_io,
  // Link pins from the device.
  input  logic [3:0] i_io
);
  integer seed = 32'he000;
  // Deselected and idle at time zero, link clock low.
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_io = 4'h0;
  end
  // Ends a frame, flips the released lines and keeps the deselect gap.
  task automatic done;
    o_cs_n = 1'b1;
    o_io = ~o_io;
    #200;
  endtask
  // Sends n bits most significant first and samples line one at every rise.
  task automatic xfer(input logic [63:0] tx, input int n, input bit keep, output logic [63:0] rx);
    rx = '0;
    o_cs_n = 1'b0;
    for (int k = n - 1; k >= 0; k--) begin
      o_io = {3'($random(seed)), tx[k]};
      #24 o_sclk = 1'b1;
      rx = {rx[62:0], i_io[1]};
      #24 o_sclk = 1'b0;
    end
    #24;
    if (!keep) begin
      done();
    end
  endtask
endmodule

/* File: sim/sfcfe_front_end_sva.sv */
// Assertion checker of the serial flash command front end.
`timescale 1ns/1ns
module sfcfe_checker (
  // Clock, reset and inputs.
  input logic        i_mclk,
  input logic        i_arst_n,
  input logic        i_cs_n,
  input logic        i_array_busy,
  input logic        i_op_done,
  // Watched outputs.
  input logic [3:0]  o_io_oe_n,
  input logic        o_op_req,
  input logic [15:0] o_status,
  input logic [15:0] o_nv_status,
  input logic        o_deep_sleep,
  input logic        o_write_arm_flag,
  input logic        o_busy_flag
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  // Relations between the command results and their causes.
  property p_float; i_cs_n |-> o_io_oe_n == 4'hf; endproperty
  a_float: assert property (p_float) else $error("lanes driven while deselected");
  property p_req_arm; o_op_req |-> $past(o_write_arm_flag); endproperty
  a_req_arm: assert property (p_req_arm) else $error("request without arm flag");
  property p_req_pulse; o_op_req |=> !o_op_req; endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("request longer than one cycle");
  property p_done_clr; i_op_done |=> !o_write_arm_flag; endproperty
  a_done_clr: assert property (p_done_clr) else $error("arm flag kept after completion");
  property p_busy_min; $rose(o_busy_flag) && !i_array_busy |-> o_busy_flag [*8]; endproperty
  a_busy_min: assert property (p_busy_min) else $error("store cycle too short");
  property p_busy_fall; $fell(o_busy_flag) |-> !o_write_arm_flag; endproperty
  a_busy_fall: assert property (p_busy_fall) else $error("arm flag set after store");
  property p_nv_busy; $changed(o_nv_status) |-> $past(o_busy_flag); endproperty
  a_nv_busy: assert property (p_nv_busy) else $error("store outside timed cycle");
  property p_sleep; $rose(o_deep_sleep) |-> i_cs_n; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep inside a frame");
  property p_arm_bit; o_status[1] == o_write_arm_flag; endproperty
  a_arm_bit: assert property (p_arm_bit) else $error("status arm bit differs");
  c_req: cover property (o_op_req);
  c_busy_end: cover property ($fell(o_busy_flag));
  c_sleep: cover property ($rose(o_deep_sleep));
endmodule
bind sfcfe_front_end sfcfe_checker u_chk (.*);

/* File: sim/serial_flash_cmd_front_end_tb.sv */
// Self-checking bench of the serial flash command front end.
`timescale 1ns/1ns
module serial_flash_cmd_front_end_tb;
  import sfcfe_pkg::*;
  localparam logic [7:0]  MK = 8'h5a;    // Arbitrary value.
  localparam logic [15:0] DV = 16'h1234; // Arbitrary value.
  localparam logic [7:0]  EL = 8'h33;    // Arbitrary value.
  logic        i_mclk, i_arst_n, i_sclk, i_cs_n, i_array_busy, i_op_done;
  logic        o_op_req, o_deep_sleep, o_write_arm_flag, o_busy_flag, o_soft_reset;
  logic [3:0]  i_io, o_io, o_io_oe_n;
  logic [7:0]  o_op_code, o_config;
  logic [23:0] o_op_addr;
  logic [1:0]  o_otp_region;
  logic [15:0] o_status, o_nv_status, st, d, nv;
  logic [63:0] rx;
  int          err_total = 0, samples_checked = 0, reqs = 0;
  sfcfe_front_end #(.STORE_CYC(200), .MAKER_ID(MK), .DEVICE_ID(DV), .ELEC_ID(EL)) dut (.*);
  sfcfe_host host (.o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_io(i_io), .i_io(o_io));
  // System clock.
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  // Counts array requests.
  always @(posedge i_mclk) if (o_op_req === 1'b1) reqs++;
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic fr(input logic [63:0] tx, input int n);
    host.xfer(tx, n, 1'b0, rx);
    @(negedge i_mclk);
  endtask
  // Bits that a two-line answer puts on line one.
  function automatic logic [3:0] odd_bits(input logic [7:0] b);
    return {b[7], b[5], b[3], b[1]};
  endfunction
  task automatic wait_idle;
    for (int i = 0; i < 600 && o_busy_flag !== 1'b0; i++) @(negedge i_mclk);
    repeat (2) @(negedge i_mclk);
  endtask
  function automatic logic [15:0] stored(input logic [15:0] old, data, keep);
    return (old & keep) | (data & ~keep);
  endfunction
  // Watchdog.
  initial begin
    #500000;
    err_total++;
    end_of_test();
  end
  // Main sequence.
  initial begin
    i_arst_n = 1'b0;
    i_array_busy = 1'b0;
    i_op_done = 1'b0;
    repeat (5) @(negedge i_mclk);
    i_arst_n = 1'b1;
    repeat (5) @(negedge i_mclk);
    chk(o_io_oe_n, 4'hf);
    chk(o_write_arm_flag, 1'b0);
    fr(OP_WRITE_ARM, 8); chk(o_write_arm_flag, 1'b1);
    fr({OP_STATUS_LO, 8'h00}, 16); chk(rx[7:0], 8'h02);
    fr(OP_WRITE_DISARM, 8); chk(o_write_arm_flag, 1'b0);
    d = 16'($random(host.seed));
    fr({OP_STATUS_STORE, d}, 24); chk(o_busy_flag, 1'b0);
    fr(OP_WRITE_ARM, 8);
    fr({OP_STATUS_STORE, d}, 24);
    st = stored(ST_RESET, {d[7:0], d[15:8]}, ST_KEEP_TWO);
    fr({OP_STATUS_LO, 8'h00}, 16); chk(rx[0], 1'b1);
    host.xfer({OP_BUSY_WATCH, 1'b1}, 9, 1'b1, rx);
    chk({o_io_oe_n[1], o_io[1]}, 2'b01);
    wait_idle();
    chk({o_io_oe_n[1], o_io[1]}, 2'b00);
    host.done(); chk(o_io_oe_n, 4'hf);
    chk(o_nv_status, st);
    nv = st;
    chk(o_write_arm_flag, 1'b0);
    d = 16'($random(host.seed));
    fr(OP_VOLATILE_ARM, 8);
    fr({OP_STATUS_STORE, d[7:0]}, 16); chk(o_busy_flag, 1'b0);
    st = stored(st, {8'h00, d[7:0]}, ST_KEEP_ONE);
    chk(o_status, st);
    fr(OP_WRITE_ARM, 8);
    fr(OP_RESET_ARM, 8);
    fr(OP_RESET, 8);
    chk({o_status, o_write_arm_flag}, {nv, 1'b0});
    fr(OP_WRITE_ARM, 8);
    fr({OP_CONFIG_STORE, d[15:8], 1'b0}, 17); wait_idle(); chk(o_config, CFG_RESET);
    fr({OP_CONFIG_STORE, d[15:8]}, 16); wait_idle(); chk(o_config, d[15:8]);
    fr({OP_CONFIG_FETCH, 8'h00}, 16); chk(rx[7:0], d[15:8]);
    for (int r = 1; r <= 3; r++) begin
      fr(OP_WRITE_ARM, 8);
      d = 16'($random(host.seed));
      fr({OP_OTP_WRITE, OTP_HI_BYTE, 7'(r * 8), d[8:0]}, 32);
      chk({8'(reqs), o_op_code, o_otp_region, o_op_addr},
          {8'(r), OP_OTP_WRITE, 2'(r), OTP_HI_BYTE, 7'(r * 8), d[8:0]});
      i_array_busy = 1'b1;
      repeat (3) @(negedge i_mclk);
      chk(o_busy_flag, 1'b1);
      i_op_done = 1'b1;
      i_array_busy = 1'b0;
      @(negedge i_mclk) i_op_done = 1'b0;
      wait_idle(); chk(o_write_arm_flag, 1'b0);
    end
    fr({OP_SECTOR_WIPE, 24'h001000}, 32); chk(reqs, 3);
    fr({OP_IDENT_FETCH, 24'h0}, 32); chk(rx[23:0], {MK, DV});
    fr({OP_MAKER_DEV, 40'h0}, 48); chk(rx[15:0], {MK, DV[7:0]});
    fr({OP_MAKER_DEV_X2, 32'h0010_0000}, 40);
    chk(rx[15:0], {odd_bits(DV[7:0]), odd_bits(MK), odd_bits(DV[7:0]), odd_bits(MK)});
    fr(OP_SLEEP_DEEP, 8); chk(o_deep_sleep, 1'b1);
    fr(OP_WRITE_ARM, 8); chk(o_write_arm_flag, 1'b0);
    fr({OP_WAKE_IDENT, 32'h0}, 40); chk(rx[7:0], EL);
    chk(o_deep_sleep, 1'b0);
    end_of_test();
  end
endmodule
